// ---- include/plsc_regs.svh ----
`ifndef PLSC_REGS_SVH
`define PLSC_REGS_SVH

// Register offsets
`define PLSC_OFS_IND_OVR      5'h18
`define PLSC_OFS_FUNC_CTRL    5'h19
`define PLSC_OFS_IRQ_STATUS   5'h1C
`define PLSC_OFS_IRQ_CLEAR    5'h1D
`define PLSC_OFS_IRQ_ENABLE   5'h1E

// Indicator override fields
`define PLSC_IND_SPD_EN       5
`define PLSC_IND_LNK_EN       4
`define PLSC_IND_ACT_EN       3
`define PLSC_IND_SPD_VAL      2
`define PLSC_IND_LNK_VAL      1
`define PLSC_IND_ACT_VAL      0
`define PLSC_IND_MSB          5
`define PLSC_IND_RST          6'h00

// Function control fields
`define PLSC_FC_AUTOX         15
`define PLSC_FC_FORCEX        14
`define PLSC_FC_PAUSE_RX      13
`define PLSC_FC_PAUSE_TX      12
`define PLSC_FC_INJECT        11
`define PLSC_FC_LONG_SEQ      10
`define PLSC_FC_RESULT        9
`define PLSC_FC_RUN           8
`define PLSC_FC_BYPASS        7

// Ability advertisement fields
`define PLSC_ADV_PAUSE        10
`define PLSC_ADV_ASM_DIR      11

// Event bits
`define PLSC_EV_FAIL          0
`define PLSC_EV_PAUSE_CHG     1
`define PLSC_EV_INJECTED      2
`define PLSC_EV_RST           3'h0

// Timing
`define PLSC_CLK_KHZ          125000
`define PLSC_STRETCH_MS       50
`define PLSC_STRETCH_CYC      (`PLSC_STRETCH_MS * `PLSC_CLK_KHZ)
`define PLSC_SYNC_BITS        4'hF
`define PLSC_PRBS_SEED        15'h7fff

`endif

// ---- include/plsc_pkg.sv ----
`default_nettype none

package plsc_pkg;

	typedef enum logic [1:0] {
		PLSC_ST_IDLE  = 2'h0,
		PLSC_ST_SYNC  = 2'h1,
		PLSC_ST_CHECK = 2'h3
	} plsc_st_e;

	typedef logic [15:0] plsc_word_t;
	typedef logic [2:0]  plsc_ind_t;
	typedef logic [14:0] plsc_prbs_t;

endpackage

`default_nettype wire

// ---- include/plsc_ind_if.sv ----
`default_nettype none

interface plsc_ind_if;
	import plsc_pkg::*;

	plsc_ind_t raw;
	plsc_ind_t stretched;
	logic      bypass;

	modport ctrl (
		output raw,
		output bypass,
		input  stretched
	);

	modport stretch (
		input  raw,
		input  bypass,
		output stretched
	);
endinterface

`default_nettype wire

// ---- core/plsc_stretch.sv ----
`include "plsc_regs.svh"
`default_nettype none

module plsc_stretch
	import plsc_pkg::*;
#(
	parameter int unsigned CYC = `PLSC_STRETCH_CYC
) (
	input wire logic    clk,
	input wire logic    rstn,
	plsc_ind_if.stretch ind
);

	logic [31:0] cnt_reg [3];
	plsc_ind_t   out_reg;

	// Hold each indicator for a minimum on time after its last pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 3; i++) begin
				cnt_reg[i] <= 32'h0000_0000;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (ind.raw[i]) begin
					cnt_reg[i] <= 32'(CYC);
				end else if (cnt_reg[i] != 32'h0000_0000) begin
					cnt_reg[i] <= cnt_reg[i] - 32'h0000_0001;
				end
			end
		end
	end

	// Bypass passes the raw status straight through
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_reg <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (ind.bypass) begin
					out_reg[i] <= ind.raw[i];
				end else begin
					out_reg[i] <= ind.raw[i] | (cnt_reg[i] != 32'h0000_0000);
				end
			end
		end
	end

	assign ind.stretched = out_reg;

endmodule

`default_nettype wire

// ---- core/plsc_top.sv ----
`include "plsc_regs.svh"
`default_nettype none

module plsc_top
	import plsc_pkg::*;
#(
	parameter int unsigned STRETCH_CYC = `PLSC_STRETCH_CYC
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        auto_crossover_strap,
	input  wire logic        auto_crossover_detect,
	input  wire logic        speed_status,
	input  wire logic        link_status,
	input  wire logic        activity_status,
	input  wire logic [15:0] local_ability_advert,
	input  wire logic [15:0] partner_ability_advert,
	input  wire logic        full_duplex_resolved,
	input  wire logic        selftest_rx_bit,
	output logic             selftest_tx_bit,
	output logic             selftest_active,
	output logic             speed_indicator_out,
	output logic             link_indicator_out,
	output logic             activity_collision_indicator_out,
	output logic             auto_crossover_en,
	output logic             pair_swap,
	output logic             pause_rx_en,
	output logic             pause_tx_en,
	output logic             irq
);

	// Next bit of the selected pseudo-random sequence
	function automatic logic prbs_fb(input logic long_sel,
	                                 input plsc_prbs_t s);
		if (long_sel) begin
			prbs_fb = s[14] ^ s[13];
		end else begin
			prbs_fb = s[8] ^ s[4];
		end
	endfunction

	function automatic logic wr_hit(input logic [4:0] ofs);
		wr_hit = reg_wr && (reg_addr == ofs);
	endfunction

	logic [5:0]  ind_reg;
	logic        strap_done_reg;
	logic        autox_reg;
	logic        forcex_reg;
	logic        inject_reg;
	logic        long_sel_reg;
	logic        result_reg;
	logic        run_reg;
	logic        bypass_reg;
	logic        pause_rx_reg;
	logic        pause_tx_reg;
	logic [2:0]  irq_sts_reg;
	logic [2:0]  irq_en_reg;
	logic        irq_reg;
	logic [15:0] rdata_reg;
	plsc_st_e    st_reg;
	plsc_st_e    st_next;
	logic [3:0]  sync_cnt_reg;
	plsc_prbs_t  gen_reg;
	plsc_prbs_t  chk_reg;
	logic        tx_bit_reg;
	logic        spd_out_reg;
	logic        lnk_out_reg;
	logic        act_out_reg;
	logic        swap_reg;
	logic        pause_rx_next;
	logic        pause_tx_next;
	logic        mismatch;
	logic        fail_ev;
	logic        inject_ev;
	logic        pause_chg_ev;
	logic [2:0]  ev_vec;
	plsc_word_t  func_word;
	plsc_word_t  ind_word;

	plsc_ind_if ind_bus ();

	plsc_stretch #(
		.CYC (STRETCH_CYC)
	) u_stretch (
		.clk  (clk),
		.rstn (rstn),
		.ind  (ind_bus)
	);

	// Indicator override register, upper bits dropped
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ind_reg <= `PLSC_IND_RST;
		end else if (wr_hit(`PLSC_OFS_IND_OVR)) begin
			ind_reg <= reg_wdata[`PLSC_IND_MSB:0];
		end
	end

	// Auto crossover: strap caught on first edge after reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_done_reg <= 1'b0;
			autox_reg      <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			autox_reg      <= auto_crossover_strap;
		end else if (wr_hit(`PLSC_OFS_FUNC_CTRL)) begin
			autox_reg <= reg_wdata[`PLSC_FC_AUTOX];
		end
	end

	// Plain read-write control bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			forcex_reg   <= 1'b0;
			long_sel_reg <= 1'b0;
			run_reg      <= 1'b0;
			bypass_reg   <= 1'b0;
		end else if (wr_hit(`PLSC_OFS_FUNC_CTRL)) begin
			forcex_reg   <= reg_wdata[`PLSC_FC_FORCEX];
			long_sel_reg <= reg_wdata[`PLSC_FC_LONG_SEQ];
			run_reg      <= reg_wdata[`PLSC_FC_RUN];
			bypass_reg   <= reg_wdata[`PLSC_FC_BYPASS];
		end
	end

	// Inject request lives one cycle, then clears itself
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			inject_reg <= 1'b0;
		end else begin
			inject_reg <= wr_hit(`PLSC_OFS_FUNC_CTRL) &&
			              reg_wdata[`PLSC_FC_INJECT];
		end
	end

	// Pattern generator
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gen_reg    <= `PLSC_PRBS_SEED;
			tx_bit_reg <= 1'b0;
		end else if (run_reg) begin
			gen_reg    <= {gen_reg[13:0], prbs_fb(long_sel_reg, gen_reg)};
			tx_bit_reg <= prbs_fb(long_sel_reg, gen_reg) ^ inject_reg;
		end else begin
			gen_reg    <= `PLSC_PRBS_SEED;
			tx_bit_reg <= 1'b0;
		end
	end

	// Self-synchronising checker history
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chk_reg <= 15'h0000;
		end else if (run_reg) begin
			chk_reg <= {chk_reg[13:0], selftest_rx_bit};
		end
	end

	assign mismatch = selftest_rx_bit != prbs_fb(long_sel_reg, chk_reg);

	// Self-test sequencing
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			PLSC_ST_IDLE: begin
				if (run_reg) begin
					st_next = PLSC_ST_SYNC;
				end
			end
			PLSC_ST_SYNC: begin
				if (!run_reg) begin
					st_next = PLSC_ST_IDLE;
				end else if (sync_cnt_reg == `PLSC_SYNC_BITS) begin
					st_next = PLSC_ST_CHECK;
				end
			end
			PLSC_ST_CHECK: begin
				if (!run_reg) begin
					st_next = PLSC_ST_IDLE;
				end
			end
			default: begin
				st_next = PLSC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= PLSC_ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_cnt_reg <= 4'h0;
		end else if (st_reg == PLSC_ST_SYNC) begin
			sync_cnt_reg <= sync_cnt_reg + 4'h1;
		end else begin
			sync_cnt_reg <= 4'h0;
		end
	end

	assign fail_ev = (st_reg == PLSC_ST_CHECK) && run_reg &&
	                 mismatch && result_reg;

	// Result: pass on start, fail latched, cleared on stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			result_reg <= 1'b0;
		end else if (!run_reg) begin
			result_reg <= 1'b0;
		end else if (st_reg == PLSC_ST_IDLE) begin
			result_reg <= 1'b1;
		end else if (fail_ev) begin
			result_reg <= 1'b0;
		end
	end

	// Pause resolution, full duplex only
	always_comb begin
		logic lp;
		logic la;
		logic rp;
		logic ra;
		lp = local_ability_advert[`PLSC_ADV_PAUSE];
		la = local_ability_advert[`PLSC_ADV_ASM_DIR];
		rp = partner_ability_advert[`PLSC_ADV_PAUSE];
		ra = partner_ability_advert[`PLSC_ADV_ASM_DIR];
		pause_rx_next = full_duplex_resolved &&
		                ((lp && rp) || (lp && la && !rp && ra));
		pause_tx_next = full_duplex_resolved &&
		                ((lp && rp) || (!lp && la && rp && ra));
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pause_rx_reg <= 1'b0;
			pause_tx_reg <= 1'b0;
		end else begin
			pause_rx_reg <= pause_rx_next;
			pause_tx_reg <= pause_tx_next;
		end
	end

	assign pause_chg_ev = (pause_rx_next != pause_rx_reg) ||
	                      (pause_tx_next != pause_tx_reg);
	assign inject_ev    = inject_reg && run_reg;

	// Crossover steering
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			swap_reg <= 1'b0;
		end else begin
			swap_reg <= forcex_reg ||
			            (autox_reg && auto_crossover_detect);
		end
	end

	// Indicator path through the stretcher
	assign ind_bus.raw    = {speed_status, link_status, activity_status};
	assign ind_bus.bypass = bypass_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			spd_out_reg <= 1'b0;
			lnk_out_reg <= 1'b0;
			act_out_reg <= 1'b0;
		end else begin
			spd_out_reg <= ind_reg[`PLSC_IND_SPD_EN] ?
			               ind_reg[`PLSC_IND_SPD_VAL] :
			               ind_bus.stretched[2];
			lnk_out_reg <= ind_reg[`PLSC_IND_LNK_EN] ?
			               ind_reg[`PLSC_IND_LNK_VAL] :
			               ind_bus.stretched[1];
			act_out_reg <= ind_reg[`PLSC_IND_ACT_EN] ?
			               ind_reg[`PLSC_IND_ACT_VAL] :
			               ind_bus.stretched[0];
		end
	end

	// Event status, enable and interrupt
	always_comb begin
		ev_vec                     = `PLSC_EV_RST;
		ev_vec[`PLSC_EV_FAIL]      = fail_ev;
		ev_vec[`PLSC_EV_PAUSE_CHG] = pause_chg_ev;
		ev_vec[`PLSC_EV_INJECTED]  = inject_ev;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_sts_reg <= `PLSC_EV_RST;
		end else if (wr_hit(`PLSC_OFS_IRQ_CLEAR)) begin
			irq_sts_reg <= (irq_sts_reg & ~reg_wdata[2:0]) | ev_vec;
		end else begin
			irq_sts_reg <= irq_sts_reg | ev_vec;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_en_reg <= `PLSC_EV_RST;
		end else if (wr_hit(`PLSC_OFS_IRQ_ENABLE)) begin
			irq_en_reg <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_sts_reg & irq_en_reg);
		end
	end

	// Read words
	always_comb begin
		ind_word                          = 16'h0000;
		ind_word[`PLSC_IND_MSB:0]         = ind_reg;
		func_word                         = 16'h0000;
		func_word[`PLSC_FC_AUTOX]         = autox_reg;
		func_word[`PLSC_FC_FORCEX]        = forcex_reg;
		func_word[`PLSC_FC_PAUSE_RX]      = pause_rx_reg;
		func_word[`PLSC_FC_PAUSE_TX]      = pause_tx_reg;
		func_word[`PLSC_FC_INJECT]        = inject_reg;
		func_word[`PLSC_FC_LONG_SEQ]      = long_sel_reg;
		func_word[`PLSC_FC_RESULT]        = result_reg;
		func_word[`PLSC_FC_RUN]           = run_reg;
		func_word[`PLSC_FC_BYPASS]        = bypass_reg;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`PLSC_OFS_IND_OVR:    rdata_reg <= ind_word;
				`PLSC_OFS_FUNC_CTRL:  rdata_reg <= func_word;
				`PLSC_OFS_IRQ_STATUS: rdata_reg <= {13'h0000, irq_sts_reg};
				`PLSC_OFS_IRQ_ENABLE: rdata_reg <= {13'h0000, irq_en_reg};
				default:              rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	assign reg_rdata                        = rdata_reg;
	assign selftest_tx_bit                  = tx_bit_reg;
	assign selftest_active                  = run_reg;
	assign speed_indicator_out              = spd_out_reg;
	assign link_indicator_out               = lnk_out_reg;
	assign activity_collision_indicator_out = act_out_reg;
	assign auto_crossover_en                = autox_reg;
	assign pair_swap                        = swap_reg;
	assign pause_rx_en                      = pause_rx_reg;
	assign pause_tx_en                      = pause_tx_reg;
	assign irq                              = irq_reg;

endmodule

`default_nettype wire

// ---- verification/plsc_properties.sv ----
`default_nettype none

module plsc_properties (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        auto_crossover_detect,
	input wire logic [15:0] local_ability_advert,
	input wire logic [15:0] partner_ability_advert,
	input wire logic        full_duplex_resolved,
	input wire logic        selftest_tx_bit,
	input wire logic        selftest_active,
	input wire logic        speed_indicator_out,
	input wire logic        link_indicator_out,
	input wire logic        activity_collision_indicator_out,
	input wire logic        auto_crossover_en,
	input wire logic        pair_swap,
	input wire logic        pause_rx_en,
	input wire logic        pause_tx_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Pause resolution, receive in bit 1, transmit in bit 0
	function automatic logic [1:0] pz(logic [15:0] l, logic [15:0] p);
		pz[1] = l[10] & p[10] | l[10] & l[11] & !p[10] & p[11];
		pz[0] = l[10] & p[10] | !l[10] & l[11] & p[10] & p[11];
	endfunction

	a_ovr_upper_zero: assert property (
		$past(reg_rd) && $past(reg_addr) == 5'h18 |-> reg_rdata[15:6] == 10'h000)
		else $error("override upper bits not zero");
	a_speed_forced: assert property (
		reg_wr && reg_addr == 5'h18 && reg_wdata[5] ##1 !reg_wr [*2]
		|-> ##1 speed_indicator_out == $past(reg_wdata[2], 3))
		else $error("speed indicator not forced");
	a_link_forced: assert property (
		reg_wr && reg_addr == 5'h18 && reg_wdata[4] ##1 !reg_wr [*2]
		|-> ##1 link_indicator_out == $past(reg_wdata[1], 3))
		else $error("link indicator not forced");
	a_activity_forced: assert property (
		reg_wr && reg_addr == 5'h18 && reg_wdata[3] ##1 !reg_wr [*2]
		|-> ##1 activity_collision_indicator_out == $past(reg_wdata[0], 3))
		else $error("activity indicator not forced");
	a_auto_cross_en: assert property (
		reg_wr && reg_addr == 5'h19 ##1 !reg_wr [*2]
		|-> ##1 auto_crossover_en == $past(reg_wdata[15], 3))
		else $error("auto crossover enable wrong");
	a_pair_swap_cause: assert property (
		reg_wr && reg_addr == 5'h19 ##1 !reg_wr [*2] |-> ##1 pair_swap ==
		($past(reg_wdata[14], 3) | $past(reg_wdata[15], 3)
		& $past(auto_crossover_detect)))
		else $error("pair swap wrong");
	a_pause_resolved: assert property (
		$past(rstn) && $past(full_duplex_resolved) |->
		{pause_rx_en, pause_tx_en} ==
		pz($past(local_ability_advert), $past(partner_ability_advert)))
		else $error("pause resolution wrong");
	a_pause_half_off: assert property (
		!$past(full_duplex_resolved) |-> !pause_rx_en && !pause_tx_en)
		else $error("pause set without full duplex");
	a_selftest_run: assert property (
		reg_wr && reg_addr == 5'h19 ##1 !reg_wr [*2]
		|-> ##1 selftest_active == $past(reg_wdata[8], 3))
		else $error("self-test run state wrong");
	a_tx_quiet_idle: assert property (
		!selftest_active && !$past(selftest_active) |-> !selftest_tx_bit)
		else $error("pattern sent while stopped");
endmodule

`default_nettype wire

// ---- verification/phy_led_and_selftest_control_tb_top.sv ----
`default_nettype none

module phy_led_and_selftest_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rstn, reg_wr, reg_rd, strap, detect, fd, rx;
	logic        spd, lnk, act, tx, run, spd_o, lnk_o, act_o;
	logic        aen, swp, prx, ptx, irq, pend = 1'h0;
	logic [1:0]  e;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, loc, par, v;
	logic [15:0] exp_q[$];
	int          num_errors = 0;
	int          tests_run = 0;
	int          i;

	plsc_top #(.STRETCH_CYC(8)) DUT (
		.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.auto_crossover_strap(strap), .auto_crossover_detect(detect),
		.speed_status(spd), .link_status(lnk), .activity_status(act),
		.local_ability_advert(loc), .partner_ability_advert(par),
		.full_duplex_resolved(fd), .selftest_rx_bit(rx),
		.selftest_tx_bit(tx), .selftest_active(run),
		.speed_indicator_out(spd_o), .link_indicator_out(lnk_o),
		.activity_collision_indicator_out(act_o), .auto_crossover_en(aen),
		.pair_swap(swp), .pause_rx_en(prx), .pause_tx_en(ptx), .irq(irq)
	);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	// Pattern loopback with one cycle of latency
	always @(posedge clk) rx <= tx;
	always @(posedge clk) pend <= reg_rd;
	always @(negedge clk) if (pend) chk_reg(exp_q.pop_front(), reg_rdata);

	task automatic chk_reg(input logic [15:0] x, input logic [15:0] g);
		tests_run++;
		if (g !== x) begin
			num_errors++;
			$display("[FAIL] reg_rdata expected %h seen %h", x, g);
		end
	endtask

	task automatic chk_pin(input string n, input logic x, input logic g);
		tests_run++;
		if (g !== x) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", n, x, g);
		end
	endtask

	// Write (w=1) or read expecting d (w=0)
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic [1:0] res(input logic [4:0] b);
		res[1] = b[4] & (b[2] & b[0] | b[2] & b[3] & !b[0] & b[1]);
		res[0] = b[4] & (b[2] & b[0] | !b[2] & b[3] & b[0] & b[1]);
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[FAIL] run expected end seen timeout");
		tally_and_finish;
	end

	initial begin
		{rstn, reg_wr, reg_rd, detect, fd, spd, lnk, act, rx} = 9'h000;
		{reg_addr, reg_wdata, loc, par} = 53'h0;
		strap = 1'h1;
		void'($urandom(50));
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		cyc(3);
		bus(0, 5'h18, 16'h0000);
		bus(0, 5'h19, 16'h8000);
		bus(0, 5'h05, 16'h0000);
		bus(0, 5'h1C, 16'h0000);
		for (i = 0; i < 12; i++) begin
			v = 16'($urandom);
			@(posedge clk);
			{spd, lnk, act} <= 3'($urandom);
			bus(1, 5'h18, v);
			bus(0, 5'h18, {10'h000, v[5:0]});
			cyc(12);
			chk_pin("speed", v[5] ? v[2] : spd, spd_o);
			chk_pin("link", v[4] ? v[1] : lnk, lnk_o);
			chk_pin("activity", v[3] ? v[0] : act, act_o);
		end
		bus(1, 5'h18, 16'h0000);
		for (i = 0; i < 2; i++) begin
			bus(1, 5'h19, {8'h00, i[0], 7'h00});
			@(posedge clk);
			lnk <= 1'h1;
			@(posedge clk);
			lnk <= 1'h0;
			cyc(4);
			chk_pin("stretch", !i[0], lnk_o);
			cyc(12);
		end
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			detect <= i[0];
			bus(1, 5'h19, {i[2:1], 14'h0000});
			cyc(3);
			chk_pin("swap", i[1] | i[2] & i[0], swp);
			chk_pin("autox", i[2], aen);
			bus(0, 5'h19, {i[2:1], 14'h0000});
		end
		bus(1, 5'h1E, 16'h0002);
		for (i = 0; i < 32; i++) begin
			@(posedge clk);
			fd <= i[4];
			loc <= {4'($urandom), i[3:2], 10'($urandom)};
			par <= {4'($urandom), i[1:0], 10'($urandom)};
			e = res(i[4:0]);
			cyc(3);
			chk_pin("pause_rx", e[1], prx);
			chk_pin("pause_tx", e[0], ptx);
			bus(0, 5'h19, {2'h3, e, 12'h000});
		end
		cyc(1);
		chk_pin("irq", 1'h1, irq);
		bus(0, 5'h1C, 16'h0002);
		bus(1, 5'h1E, 16'h0000);
		cyc(2);
		chk_pin("irq_masked", 1'h0, irq);
		bus(1, 5'h1E, 16'h0002);
		cyc(2);
		chk_pin("irq", 1'h1, irq);
		bus(1, 5'h1D, 16'h0002);
		bus(0, 5'h1C, 16'h0000);
		bus(0, 5'h1D, 16'h0000);
		cyc(2);
		chk_pin("irq_clear", 1'h0, irq);
		for (i = 0; i < 2; i++) begin
			v = {5'h00, i[0], 2'h1, 8'h00};
			bus(1, 5'h19, v);
			cyc(40);
			bus(0, 5'h19, v | 16'h3200);
			bus(1, 5'h19, v | 16'h0800);
			cyc(30);
			bus(0, 5'h19, v | 16'h3000);
			bus(0, 5'h1C, 16'h0005);
			bus(1, 5'h19, 16'h0000);
			bus(0, 5'h19, 16'h3000);
			bus(1, 5'h1D, 16'h0007);
		end
		// Second reset with the strap low: enable must come up clear
		@(posedge clk);
		rstn <= 1'h0;
		strap <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		cyc(3);
		chk_pin("autox_strap", 1'h0, aen);
		bus(0, 5'h19, 16'h3000);
		cyc(4);
		tally_and_finish;
	end
endmodule

bind plsc_top plsc_properties u_props (
	.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.auto_crossover_detect(auto_crossover_detect),
	.local_ability_advert(local_ability_advert),
	.partner_ability_advert(partner_ability_advert),
	.full_duplex_resolved(full_duplex_resolved),
	.selftest_tx_bit(selftest_tx_bit), .selftest_active(selftest_active),
	.speed_indicator_out(speed_indicator_out),
	.link_indicator_out(link_indicator_out),
	.activity_collision_indicator_out(activity_collision_indicator_out),
	.auto_crossover_en(auto_crossover_en), .pair_swap(pair_swap),
	.pause_rx_en(pause_rx_en), .pause_tx_en(pause_tx_en)
);

`default_nettype wire
